// [logic/ipes_defines.vh]
// event codes and field layouts for the performance event selector
// assumes the including file sets widths through its own parameters
`ifndef IPES_DEFINES_VH
`define IPES_DEFINES_VH

// event code width
`define IPES_CODE_W            8

// message interrupt events
`define IPES_EV_MSG_CMD_RESP   8'h2e
`define IPES_EV_STORED_HOME    8'h30
`define IPES_EV_STORED_OTHER   8'h31
`define IPES_EV_HIT_EN         8'h32
`define IPES_EV_HIT_DIS        8'h33
`define IPES_EV_HIT_ANY        8'h34
`define IPES_EV_COALESCED      8'h35
`define IPES_EV_FREE_SLOTS     8'h36
`define IPES_EV_FETCH_EN       8'h37
`define IPES_EV_FETCH_DIS      8'h38
`define IPES_EV_FETCH_ANY      8'h39

// shared interrupt events
`define IPES_EV_SHR_COLLATOR   8'h50
`define IPES_EV_SHR_ENABLED    8'h51
`define IPES_EV_SHR_DISABLED   8'h52
`define IPES_EV_SHR_PEND_SET   8'h53
`define IPES_EV_SHR_PEND_CLR   8'h54
`define IPES_EV_SHR_MERGED     8'h55
`define IPES_EV_SHR_FROM_REM   8'h57
`define IPES_EV_SHR_TO_REM     8'h58
`define IPES_EV_SHR_REM_RESP   8'h59
`define IPES_EV_SHR_DEACT      8'h5a
`define IPES_EV_SHR_DEACT_RESP 8'h5b

// pending table events
`define IPES_EV_PT_WRITE_EN    8'h60

// attribute source selects
`define IPES_DOM_MSG           2'h0
`define IPES_DOM_SHR           2'h1
`define IPES_DOM_PT            2'h2

`endif

// [logic/ipes_match.v]
// filter comparator: target, id range, chip and view against one filter set
// assumes all inputs are on the caller's clock; purely combinational
`timescale 1ns/10ps
module ipes_match #(
  parameter TGTW  = 8,
  parameter IDW   = 16,
  parameter CHIPW = 4,
  parameter VIEWW = 2
) (
  // event attributes
  input  wire [TGTW-1:0]  attr_tgt,
  input  wire [IDW-1:0]   attr_id,
  input  wire [CHIPW-1:0] attr_chip,
  input  wire [VIEWW-1:0] attr_view,
  // filter set
  input  wire [TGTW-1:0]  flt_tgt,
  input  wire             flt_tgt_en,
  input  wire [IDW-1:0]   flt_id_lo,
  input  wire [IDW-1:0]   flt_id_hi,
  input  wire             flt_id_en,
  input  wire [CHIPW-1:0] flt_chip,
  input  wire             flt_chip_en,
  input  wire [VIEWW-1:0] flt_view,
  input  wire             flt_view_en,
  // which filters the event code applies
  input  wire             use_tgt,
  input  wire             use_id,
  input  wire             use_chip,
  input  wire             use_view,
  // result
  output wire             hit
);

  wire tgt_ok;
  wire id_ok;
  wire chip_ok;
  wire view_ok;

  assign tgt_ok  = ~(use_tgt & flt_tgt_en) | (attr_tgt == flt_tgt);
  assign id_ok   = ~(use_id & flt_id_en) | ((attr_id >= flt_id_lo) & (attr_id <= flt_id_hi));
  assign chip_ok = ~(use_chip & flt_chip_en) | (attr_chip == flt_chip);
  assign view_ok = ~(use_view & flt_view_en) | (attr_view == flt_view);
  assign hit     = tgt_ok & id_ok & chip_ok & view_ok;

endmodule

// [logic/ipes_top.v]
// event selection and qualification for the performance counters
// assumes all event strobes and filters come from logic on MCLK
`timescale 1ns/10ps
`include "ipes_defines.vh"

// Contract
// - code 2e counts remote message command responses, unmasked, chip filter only.
// - code 30 counts home-slot stores and holds both clock gating kinds off.
// - code 31 counts other-slot stores, no filter, holds all clock gating off.
// - codes 32-34 count property cache hits, counter 0 target and id filters.
// - code 35 counts coalesced messages using counter 0 target and id filters.
// - code 36 adds free slot count on each new message, unfiltered.
// - codes 37-39 count property fetches, counter 0 target and id filters.
// - code 50 counts collator messages, view and id range filtered.
// - shared codes 50-5b suppressed for group 0 or secure group 1.
// - code 51 counts shared interrupts seen enabled.
// - code 52 counts shared interrupts seen disabled.
// - code 53 counts new valid pending, code 54 counts pending clears.
// - code 55 counts edge merges, excluding merges inside the collator.
// - codes 57, 58 count remote in and out, id and chip, no view.
// - code 59 counts remote shared responses, chip filter only.
// - code 5a counts deactivates sent, 5b their responses with chip filter.
// - code 60 counts enabled pending table writes, target and id filtered.
module ipes_top #(
  parameter NCNT  = 4,
  parameter INCW  = 8,
  parameter TGTW  = 8,
  parameter IDW   = 16,
  parameter CHIPW = 4,
  parameter VIEWW = 2
) (
  // clock and reset
  input  wire                    MCLK,
  input  wire                    ARST_N,
  // counter selection and filters
  input  wire [NCNT-1:0]         CNT_EN,
  input  wire [NCNT*8-1:0]       CNT_EVENT,
  input  wire [NCNT*TGTW-1:0]    FLT_TGT,
  input  wire [NCNT-1:0]         FLT_TGT_EN,
  input  wire [NCNT*IDW-1:0]     FLT_ID_LO,
  input  wire [NCNT*IDW-1:0]     FLT_ID_HI,
  input  wire [NCNT-1:0]         FLT_ID_EN,
  input  wire [NCNT*CHIPW-1:0]   FLT_CHIP,
  input  wire [NCNT-1:0]         FLT_CHIP_EN,
  input  wire [NCNT*VIEWW-1:0]   FLT_VIEW,
  input  wire [NCNT-1:0]         FLT_VIEW_EN,
  // message interrupt strobes
  input  wire                    MSG_CMD_REMOTE_RESPONSE,
  input  wire                    MSG_STORED_HOME_SLOT,
  input  wire                    MSG_STORED_OTHER_SLOT,
  input  wire                    PROP_CACHE_HIT,
  input  wire                    PROP_FETCH,
  input  wire                    MSG_PROP_ENABLED,
  input  wire                    MSG_COALESCED,
  input  wire                    MSG_NEW_ARRIVAL,
  input  wire [INCW-1:0]         MSG_FREE_SLOTS,
  // message interrupt attributes
  input  wire [TGTW-1:0]         MSG_TARGET,
  input  wire [IDW-1:0]          MSG_ID,
  input  wire [CHIPW-1:0]        MSG_CHIP,
  // shared interrupt strobes
  input  wire                    SHARED_COLLATOR_MESSAGE,
  input  wire                    SHARED_SEEN_ENABLED,
  input  wire                    SHARED_SEEN_DISABLED,
  input  wire                    SHARED_PENDING_SET,
  input  wire                    SHARED_PENDING_CLEARED,
  input  wire                    SHARED_EDGE_MERGED,
  input  wire                    SHARED_MERGE_IN_COLLATOR,
  input  wire                    SHARED_FROM_REMOTE,
  input  wire                    SHARED_TO_REMOTE,
  input  wire                    SHARED_REMOTE_RESPONSE,
  input  wire                    SHARED_DEACT_SENT,
  input  wire                    SHARED_DEACT_RESPONSE,
  // shared interrupt attributes
  input  wire [IDW-1:0]          SHARED_ID,
  input  wire [CHIPW-1:0]        SHARED_CHIP,
  input  wire [VIEWW-1:0]        SHARED_VIEW,
  input  wire                    SHARED_GROUP0,
  input  wire                    SHARED_SECURE_GROUP1,
  // pending table strobe and attributes
  input  wire                    PEND_TABLE_WRITE_ENABLED,
  input  wire [TGTW-1:0]         PT_TARGET,
  input  wire [IDW-1:0]          PT_ID,
  // counter increments and clock gating holds
  output wire [NCNT*INCW-1:0]    CNT_INC,
  output reg                     CG_HOLD,
  output reg                     QCH_CG_HOLD
);

  localparam [INCW-1:0] ONE = {{(INCW-1){1'b0}}, 1'b1};

  reg              rst_meta_q;
  reg              rst_sync_q;
  wire             rst_n;
  wire [NCNT-1:0]  hold_vec;
  wire             shr_secure;

  // reset release through two flops
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  assign shr_secure = SHARED_GROUP0 | SHARED_SECURE_GROUP1;

  genvar g;
  generate
    for (g = 0; g < NCNT; g = g + 1) begin : cnt
      wire [7:0]       code;
      reg              strobe;
      reg              use_c0;
      reg              u_tgt;
      reg              u_id;
      reg              u_chip;
      reg              u_view;
      reg              grp_mask;
      reg [1:0]        dom;
      reg [INCW-1:0]   amount;
      reg [TGTW-1:0]   a_tgt;
      reg [IDW-1:0]    a_id;
      reg [CHIPW-1:0]  a_chip;
      wire             hit;
      wire [INCW-1:0]  inc_d;
      reg  [INCW-1:0]  inc_q;

      assign code = CNT_EVENT[g*8 +: 8];

      // event decode: strobe, filter use, masking, amount
      always @* begin
        strobe   = 1'b0;
        use_c0   = 1'b0;
        u_tgt    = 1'b0;
        u_id     = 1'b0;
        u_chip   = 1'b0;
        u_view   = 1'b0;
        grp_mask = 1'b0;
        dom      = `IPES_DOM_MSG;
        amount   = ONE;
        case (code)
          `IPES_EV_MSG_CMD_RESP: begin
            strobe = MSG_CMD_REMOTE_RESPONSE;
            u_chip = 1'b1;
          end
          `IPES_EV_STORED_HOME: begin
            strobe = MSG_STORED_HOME_SLOT;
          end
          `IPES_EV_STORED_OTHER: begin
            strobe = MSG_STORED_OTHER_SLOT;
          end
          `IPES_EV_HIT_EN: begin
            strobe = PROP_CACHE_HIT & MSG_PROP_ENABLED;
            use_c0 = 1'b1;
            u_tgt  = 1'b1;
            u_id   = 1'b1;
          end
          `IPES_EV_HIT_DIS: begin
            strobe = PROP_CACHE_HIT & ~MSG_PROP_ENABLED;
            use_c0 = 1'b1;
            u_tgt  = 1'b1;
            u_id   = 1'b1;
          end
          `IPES_EV_HIT_ANY: begin
            strobe = PROP_CACHE_HIT;
            use_c0 = 1'b1;
            u_tgt  = 1'b1;
            u_id   = 1'b1;
          end
          `IPES_EV_COALESCED: begin
            strobe = MSG_COALESCED;
            use_c0 = 1'b1;
            u_tgt  = 1'b1;
            u_id   = 1'b1;
          end
          `IPES_EV_FREE_SLOTS: begin
            strobe = MSG_NEW_ARRIVAL;
            amount = MSG_FREE_SLOTS;
          end
          `IPES_EV_FETCH_EN: begin
            strobe = PROP_FETCH & MSG_PROP_ENABLED;
            use_c0 = 1'b1;
            u_tgt  = 1'b1;
            u_id   = 1'b1;
          end
          `IPES_EV_FETCH_DIS: begin
            strobe = PROP_FETCH & ~MSG_PROP_ENABLED;
            use_c0 = 1'b1;
            u_tgt  = 1'b1;
            u_id   = 1'b1;
          end
          `IPES_EV_FETCH_ANY: begin
            strobe = PROP_FETCH;
            use_c0 = 1'b1;
            u_tgt  = 1'b1;
            u_id   = 1'b1;
          end
          `IPES_EV_SHR_COLLATOR, `IPES_EV_SHR_ENABLED, `IPES_EV_SHR_DISABLED,
          `IPES_EV_SHR_PEND_SET, `IPES_EV_SHR_PEND_CLR, `IPES_EV_SHR_MERGED: begin
            dom      = `IPES_DOM_SHR;
            grp_mask = 1'b1;
            u_view   = 1'b1;
            u_id     = 1'b1;
            if (code == `IPES_EV_SHR_COLLATOR) begin
              strobe = SHARED_COLLATOR_MESSAGE;
            end else if (code == `IPES_EV_SHR_ENABLED) begin
              strobe = SHARED_SEEN_ENABLED;
            end else if (code == `IPES_EV_SHR_DISABLED) begin
              strobe = SHARED_SEEN_DISABLED;
            end else if (code == `IPES_EV_SHR_PEND_SET) begin
              strobe = SHARED_PENDING_SET;
            end else if (code == `IPES_EV_SHR_PEND_CLR) begin
              strobe = SHARED_PENDING_CLEARED;
            end else begin
              strobe = SHARED_EDGE_MERGED & ~SHARED_MERGE_IN_COLLATOR;
            end
          end
          `IPES_EV_SHR_FROM_REM, `IPES_EV_SHR_TO_REM, `IPES_EV_SHR_DEACT: begin
            dom      = `IPES_DOM_SHR;
            grp_mask = 1'b1;
            u_id     = 1'b1;
            u_chip   = 1'b1;
            if (code == `IPES_EV_SHR_FROM_REM) begin
              strobe = SHARED_FROM_REMOTE;
            end else if (code == `IPES_EV_SHR_TO_REM) begin
              strobe = SHARED_TO_REMOTE;
            end else begin
              strobe = SHARED_DEACT_SENT;
            end
          end
          `IPES_EV_SHR_REM_RESP: begin
            dom      = `IPES_DOM_SHR;
            grp_mask = 1'b1;
            u_chip   = 1'b1;
            strobe   = SHARED_REMOTE_RESPONSE;
          end
          `IPES_EV_SHR_DEACT_RESP: begin
            dom      = `IPES_DOM_SHR;
            grp_mask = 1'b1;
            u_chip   = 1'b1;
            strobe   = SHARED_DEACT_RESPONSE;
          end
          `IPES_EV_PT_WRITE_EN: begin
            dom    = `IPES_DOM_PT;
            strobe = PEND_TABLE_WRITE_ENABLED;
            u_tgt  = 1'b1;
            u_id   = 1'b1;
          end
          default: begin
            strobe = 1'b0;
          end
        endcase
      end

      // attributes of the selected source
      always @* begin
        a_tgt  = MSG_TARGET;
        a_id   = MSG_ID;
        a_chip = MSG_CHIP;
        if (dom == `IPES_DOM_SHR) begin
          a_tgt  = {TGTW{1'b0}};
          a_id   = SHARED_ID;
          a_chip = SHARED_CHIP;
        end else if (dom == `IPES_DOM_PT) begin
          a_tgt  = PT_TARGET;
          a_id   = PT_ID;
          a_chip = {CHIPW{1'b0}};
        end
      end

      // own filter set, or counter 0's for codes tied to it
      ipes_match #(
        .TGTW  (TGTW),
        .IDW   (IDW),
        .CHIPW (CHIPW),
        .VIEWW (VIEWW)
      ) u_match (
        .attr_tgt    (a_tgt),
        .attr_id     (a_id),
        .attr_chip   (a_chip),
        .attr_view   (SHARED_VIEW),
        .flt_tgt     (use_c0 ? FLT_TGT[TGTW-1:0] : FLT_TGT[g*TGTW +: TGTW]),
        .flt_tgt_en  (use_c0 ? FLT_TGT_EN[0] : FLT_TGT_EN[g]),
        .flt_id_lo   (use_c0 ? FLT_ID_LO[IDW-1:0] : FLT_ID_LO[g*IDW +: IDW]),
        .flt_id_hi   (use_c0 ? FLT_ID_HI[IDW-1:0] : FLT_ID_HI[g*IDW +: IDW]),
        .flt_id_en   (use_c0 ? FLT_ID_EN[0] : FLT_ID_EN[g]),
        .flt_chip    (FLT_CHIP[g*CHIPW +: CHIPW]),
        .flt_chip_en (FLT_CHIP_EN[g]),
        .flt_view    (FLT_VIEW[g*VIEWW +: VIEWW]),
        .flt_view_en (FLT_VIEW_EN[g]),
        .use_tgt     (u_tgt),
        .use_id      (u_id),
        .use_chip    (u_chip),
        .use_view    (u_view),
        .hit         (hit)
      );

      // qualified increment, suppressed for secure groups
      assign inc_d = (CNT_EN[g] & strobe & hit & ~(grp_mask & shr_secure)) ? amount : {INCW{1'b0}};

      always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
          inc_q <= {INCW{1'b0}};
        end else if (!rst_n) begin
          inc_q <= {INCW{1'b0}};
        end else begin
          inc_q <= inc_d;
        end
      end
      assign CNT_INC[g*INCW +: INCW] = inc_q;

      // stored-slot events keep the clocks running
      assign hold_vec[g] = CNT_EN[g] & ((code == `IPES_EV_STORED_HOME) | (code == `IPES_EV_STORED_OTHER));
    end
  endgenerate

  // clock gating holds
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CG_HOLD     <= 1'b0;
      QCH_CG_HOLD <= 1'b0;
    end else if (!rst_n) begin
      CG_HOLD     <= 1'b0;
      QCH_CG_HOLD <= 1'b0;
    end else begin
      CG_HOLD     <= |hold_vec;
      QCH_CG_HOLD <= |hold_vec;
    end
  end

endmodule

// [verif/ipes_checker.sv]
// assertions on the event selector ports
// assumes it is bound into ipes_top and sees only its ports
`timescale 1ns/10ps
module ipes_checker #(
  parameter NCNT = 4,
  parameter INCW = 8
) (
  // clock and reset
  input logic                 MCLK,
  input logic                 ARST_N,
  // selection and strobes
  input logic [NCNT-1:0]      CNT_EN,
  input logic [NCNT*8-1:0]    CNT_EVENT,
  input logic [NCNT-1:0]      FLT_CHIP_EN,
  input logic                 MSG_CMD_REMOTE_RESPONSE,
  input logic                 MSG_STORED_OTHER_SLOT,
  input logic                 MSG_NEW_ARRIVAL,
  input logic [INCW-1:0]      MSG_FREE_SLOTS,
  input logic                 SHARED_MERGE_IN_COLLATOR,
  input logic                 SHARED_GROUP0,
  input logic                 SHARED_SECURE_GROUP1,
  // results
  input logic [NCNT*INCW-1:0] CNT_INC,
  input logic                 CG_HOLD,
  input logic                 QCH_CG_HOLD
);
  logic [1:0]      rc_q;
  logic            sel_hold;
  logic [7:0]      ev0;
  logic [INCW-1:0] inc0;
  assign ev0  = CNT_EVENT[7:0];
  assign inc0 = CNT_INC[INCW-1:0];
  always_comb begin
    sel_hold = 1'b0;
    for (int g = 0; g < NCNT; g++)
      if (CNT_EN[g] && (CNT_EVENT[g*8+:8] inside {8'h30, 8'h31}))
        sel_hold = 1'b1;
  end
  // cycles since reset release
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N)
      rc_q <= 2'h0;
    else if (rc_q != 2'h3)
      rc_q <= rc_q + 2'h1;
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N || rc_q != 2'h3);
  a_hold_both_kinds: assert property (CNT_EN[0] && ev0 == 8'h30 |=> CG_HOLD && QCH_CG_HOLD)
    else $error("home slot select did not hold both gating kinds");
  a_hold_any_select: assert property (sel_hold |=> CG_HOLD && QCH_CG_HOLD)
    else $error("slot select did not hold clock gating");
  a_hold_release: assert property (!sel_hold |=> !CG_HOLD && !QCH_CG_HOLD)
    else $error("clock gating hold without a slot select");
  a_other_slot_count: assert property (CNT_EN[0] && ev0 == 8'h31 && MSG_STORED_OTHER_SLOT |=> inc0 == 1)
    else $error("other slot store not counted");
  a_free_amount: assert property (CNT_EN[0] && ev0 == 8'h36 && MSG_NEW_ARRIVAL |=> inc0 == $past(MSG_FREE_SLOTS))
    else $error("free slot amount not added");
  a_group_mask: assert property ((ev0 inside {[8'h50:8'h5b]}) && (SHARED_GROUP0 || SHARED_SECURE_GROUP1) |=> inc0 == 0)
    else $error("masked shared event counted");
  a_collator_merge: assert property (ev0 == 8'h55 && SHARED_MERGE_IN_COLLATOR |=> inc0 == 0)
    else $error("collator merge counted");
  a_resp_unmasked: assert property (CNT_EN[0] && ev0 == 8'h2e && MSG_CMD_REMOTE_RESPONSE && !FLT_CHIP_EN[0]
    |=> inc0 == 1)
    else $error("remote command response not counted");
  a_disabled_idle: assert property (CNT_EN == 0 |=> CNT_INC == 0)
    else $error("disabled counters gave an increment");
  c_hold: cover property (CG_HOLD);
  c_amount: cover property (inc0 > 1);
  c_masked: cover property (CNT_EN[0] && ev0 == 8'h53 && SHARED_GROUP0);
endmodule

bind ipes_top ipes_checker #(.NCNT(NCNT), .INCW(INCW)) u_chk (.*);

// [verif/tb_ipes_top.sv]
// self-checking bench for the event selector
// assumes ipes_top with default widths and the bound checker
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_ipes_top;
  logic        MCLK = 1'b0, ARST_N = 1'b0, MSG_PROP_ENABLED = 1'b0, SHARED_MERGE_IN_COLLATOR = 1'b0;
  logic        SHARED_GROUP0 = 1'b0, SHARED_SECURE_GROUP1 = 1'b0, CG_HOLD, QCH_CG_HOLD;
  logic [3:0]  CNT_EN = 4'h1, FLT_TGT_EN = 4'h0, FLT_ID_EN = 4'h0, FLT_CHIP_EN = 4'h0, FLT_VIEW_EN = 4'h0;
  logic [31:0] CNT_EVENT = 32'h30, FLT_TGT = 32'h0, CNT_INC;
  logic [63:0] FLT_ID_LO = 64'h0, FLT_ID_HI = 64'h0;
  logic [15:0] FLT_CHIP = 16'h0, MSG_ID = 16'h0, SHARED_ID = 16'h0, PT_ID = 16'h0;
  logic [7:0]  FLT_VIEW = 8'h0, MSG_TARGET = 8'h0, PT_TARGET = 8'h0, MSG_FREE_SLOTS = 8'h05;
  logic [3:0]  MSG_CHIP = 4'h0, SHARED_CHIP = 4'h0;
  logic [1:0]  SHARED_VIEW = 2'h0;
  logic [18:0] stb = 19'h0;
  int          n_errors = 0, cmp_count = 0;
  // code, strobe index, prop enabled, expected increment
  logic [21:0] rows [30] = '{
    {8'h2e,5'd0,1'b0,8'h01}, {8'h30,5'd1,1'b0,8'h01}, {8'h31,5'd2,1'b0,8'h01}, {8'h32,5'd3,1'b1,8'h01},
    {8'h32,5'd3,1'b0,8'h00}, {8'h33,5'd3,1'b0,8'h01}, {8'h33,5'd3,1'b1,8'h00}, {8'h34,5'd3,1'b0,8'h01},
    {8'h34,5'd3,1'b1,8'h01}, {8'h35,5'd5,1'b0,8'h01}, {8'h36,5'd6,1'b0,8'h05}, {8'h37,5'd4,1'b1,8'h01},
    {8'h37,5'd4,1'b0,8'h00}, {8'h38,5'd4,1'b0,8'h01}, {8'h38,5'd4,1'b1,8'h00}, {8'h39,5'd4,1'b0,8'h01},
    {8'h50,5'd7,1'b0,8'h01}, {8'h51,5'd8,1'b0,8'h01}, {8'h52,5'd9,1'b0,8'h01}, {8'h53,5'd10,1'b0,8'h01},
    {8'h54,5'd11,1'b0,8'h01}, {8'h55,5'd12,1'b0,8'h01}, {8'h57,5'd13,1'b0,8'h01}, {8'h58,5'd14,1'b0,8'h01},
    {8'h59,5'd15,1'b0,8'h01}, {8'h5a,5'd16,1'b0,8'h01}, {8'h5b,5'd17,1'b0,8'h01}, {8'h60,5'd18,1'b0,8'h01},
    {8'h50,5'd8,1'b0,8'h00}, {8'h56,5'd12,1'b0,8'h00}};

  ipes_top u_dut (.*, .MSG_CMD_REMOTE_RESPONSE(stb[0]), .MSG_STORED_HOME_SLOT(stb[1]),
    .MSG_STORED_OTHER_SLOT(stb[2]), .PROP_CACHE_HIT(stb[3]), .PROP_FETCH(stb[4]), .MSG_COALESCED(stb[5]),
    .MSG_NEW_ARRIVAL(stb[6]), .SHARED_COLLATOR_MESSAGE(stb[7]), .SHARED_SEEN_ENABLED(stb[8]),
    .SHARED_SEEN_DISABLED(stb[9]), .SHARED_PENDING_SET(stb[10]), .SHARED_PENDING_CLEARED(stb[11]),
    .SHARED_EDGE_MERGED(stb[12]), .SHARED_FROM_REMOTE(stb[13]), .SHARED_TO_REMOTE(stb[14]),
    .SHARED_REMOTE_RESPONSE(stb[15]), .SHARED_DEACT_SENT(stb[16]), .SHARED_DEACT_RESPONSE(stb[17]),
    .PEND_TABLE_WRITE_ENABLED(stb[18]));

  initial begin
    forever #4 MCLK = ~MCLK;
  end

  task final_report;
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one strobe pulse, increment seen one cycle later
  task automatic fire(input int c, input [4:0] i, input [7:0] e);
    @(posedge MCLK);
    stb <= 19'h1 << i;
    @(posedge MCLK);
    stb <= 19'h0;
    #1 `CHK(CNT_INC[c*8+:8], e)
  endtask

  task hc(input [1:0] e);
    @(posedge MCLK);
    #1 `CHK({CG_HOLD, QCH_CG_HOLD}, e)
  endtask

  initial begin
    repeat (20000) @(posedge MCLK);
    n_errors++;
    final_report;
  end

  initial begin
    repeat (16) @(posedge MCLK);
    `CHK({CNT_INC, CG_HOLD, QCH_CG_HOLD}, 34'h0)
    ARST_N <= 1'b1;
    repeat (4) @(posedge MCLK);
    for (int r = 0; r < 30; r++) begin
      @(posedge MCLK);
      CNT_EVENT[7:0] <= rows[r][21:14];
      MSG_PROP_ENABLED <= rows[r][8];
      fire(0, rows[r][13:9], rows[r][7:0]);
    end
    @(posedge MCLK);
    CNT_EVENT <= 32'h3130_0000;
    CNT_EN <= 4'h4;
    hc(2'h3);
    @(posedge MCLK);
    CNT_EN <= 4'h8;
    hc(2'h3);
    @(posedge MCLK);
    CNT_EN <= 4'h3;
    hc(2'h0);
    for (int r = 16; r < 27; r++) begin
      @(posedge MCLK);
      CNT_EVENT[7:0] <= rows[r][21:14];
      SHARED_GROUP0 <= r[0];
      SHARED_SECURE_GROUP1 <= !r[0];
      fire(0, rows[r][13:9], 8'h00);
    end
    @(posedge MCLK);
    SHARED_GROUP0 <= 1'b0;
    SHARED_SECURE_GROUP1 <= 1'b0;
    CNT_EVENT[7:0] <= 8'h55;
    SHARED_MERGE_IN_COLLATOR <= 1'b1;
    fire(0, 12, 8'h00);
    @(posedge MCLK);
    SHARED_MERGE_IN_COLLATOR <= 1'b0;
    CNT_EN <= 4'h2;
    CNT_EVENT[15:8] <= 8'h35;
    FLT_TGT[15:0] <= 16'haa11;
    FLT_TGT_EN <= 4'h3;
    MSG_TARGET <= 8'h11;
    fire(1, 5, 8'h01);
    @(posedge MCLK);
    MSG_TARGET <= 8'haa;
    fire(1, 5, 8'h00);
    @(posedge MCLK);
    CNT_EVENT[15:8] <= 8'h32;
    MSG_PROP_ENABLED <= 1'b1;
    fire(1, 3, 8'h00);
    @(posedge MCLK);
    MSG_TARGET <= 8'h11;
    CNT_EVENT[15:8] <= 8'h37;
    fire(1, 4, 8'h01);
    @(posedge MCLK);
    CNT_EN <= 4'h1;
    CNT_EVENT[7:0] <= 8'h50;
    FLT_ID_LO[15:0] <= 16'h000a;
    FLT_ID_HI[15:0] <= 16'h0014;
    FLT_ID_EN <= 4'h1;
    SHARED_ID <= 16'h0014;
    fire(0, 7, 8'h01);
    @(posedge MCLK);
    SHARED_ID <= 16'h0015;
    fire(0, 7, 8'h00);
    @(posedge MCLK);
    SHARED_ID <= 16'h000a;
    FLT_VIEW_EN <= 4'h1;
    FLT_VIEW[1:0] <= 2'h1;
    SHARED_VIEW <= 2'h2;
    fire(0, 7, 8'h00);
    @(posedge MCLK);
    CNT_EVENT[7:0] <= 8'h57;
    fire(0, 13, 8'h01);
    @(posedge MCLK);
    FLT_CHIP_EN <= 4'h1;
    FLT_CHIP[3:0] <= 4'h3;
    SHARED_CHIP <= 4'h4;
    fire(0, 13, 8'h00);
    @(posedge MCLK);
    CNT_EVENT[7:0] <= 8'h59;
    SHARED_ID <= 16'h001e;
    SHARED_CHIP <= 4'h3;
    fire(0, 15, 8'h01);
    @(posedge MCLK);
    CNT_EVENT[7:0] <= 8'h2e;
    MSG_CHIP <= 4'h4;
    fire(0, 0, 8'h00);
    @(posedge MCLK);
    CNT_EVENT[7:0] <= 8'h60;
    PT_TARGET <= 8'h22;
    PT_ID <= 16'h000f;
    fire(0, 18, 8'h00);
    @(posedge MCLK);
    PT_TARGET <= 8'h11;
    fire(0, 18, 8'h01);
    @(posedge MCLK);
    CNT_EVENT[7:0] <= 8'h36;
    stb <= 19'h40;
    MSG_FREE_SLOTS <= 8'h07;
    @(posedge MCLK);
    MSG_FREE_SLOTS <= 8'h09;
    #1 `CHK(CNT_INC[7:0], 8'h07)
    @(posedge MCLK);
    stb <= 19'h0;
    #1 `CHK(CNT_INC[7:0], 8'h09)
    @(posedge MCLK);
    #1 `CHK(CNT_INC[7:0], 8'h00)
    @(posedge MCLK);
    CNT_EN <= 4'h2;
    CNT_EVENT[15:8] <= 8'h39;
    MSG_ID <= 16'h0015;
    fire(1, 4, 8'h00);
    @(posedge MCLK);
    CNT_EN <= 4'h0;
    CNT_EVENT <= 32'h582e_2e34;
    fire(0, 3, 8'h00);
    @(posedge MCLK);
    CNT_EN <= 4'hc;
    FLT_CHIP <= 16'h5403;
    FLT_CHIP_EN <= 4'h5;
    fire(2, 0, 8'h01);
    fire(3, 14, 8'h01);
    final_report;
  end
endmodule
